// ===== hw/lwdt_pkg.sv
// Constants, field positions and carrier types of the watchdog block.
// Assumes one 250 MHz clock and a host I/O cycle decoder in front.
package lwdt_pkg;

  // ----------------------------------------------------------------
  // Ports on the host I/O space
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_INDEX_PORT = 16'h0302;
  localparam logic [15:0] CFG_DATA_PORT = 16'h0303;
  localparam logic [15:0] POSTCODE_PORT = 16'h0080;
  localparam logic [7:0] KEY_FIRST = 8'h46;
  localparam logic [7:0] KEY_SECOND = 8'h57;
  localparam logic [7:0] UNIT_WDT = 8'h01;

  // ----------------------------------------------------------------
  // Configuration indexes
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_UNIT_SEL = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BLOCK = 8'h38;
  localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_BASE_LOW = 8'h61;
  localparam logic [7:0] IDX_IRQ_ROUTE = 8'h70;
  localparam logic [7:0] IDX_RESTART_EN = 8'hF1;
  localparam logic [7:0] IDX_WIN1_LOW = 8'hF2;
  localparam logic [7:0] IDX_WIN1_HIGH = 8'hF3;
  localparam logic [7:0] IDX_WIN2_LOW = 8'hF4;
  localparam logic [7:0] IDX_WIN2_HIGH = 8'hF5;
  localparam logic [7:0] IDX_WIN_MASKS = 8'hF6;

  // ----------------------------------------------------------------
  // Block offsets from the I/O base, and field positions
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_NOW0 = 3'h0;
  localparam logic [2:0] OFS_NOW2 = 3'h2;
  localparam logic [2:0] OFS_RELOAD0 = 3'h3;
  localparam logic [2:0] OFS_RELOAD1 = 3'h4;
  localparam logic [2:0] OFS_RELOAD2 = 3'h5;
  localparam logic [2:0] OFS_FLAGS = 3'h6;
  localparam logic [2:0] OFS_CONTROL = 3'h7;
  localparam int BIT_POSTCODE_EN = 4;
  localparam int BIT_WIN2_WR_EN = 3;
  localparam int BIT_WIN2_RD_EN = 2;
  localparam int BIT_WIN1_WR_EN = 1;
  localparam int BIT_WIN1_RD_EN = 0;
  localparam int BIT_SECOND_TO = 2;
  localparam int BIT_SMI_ROUTE = 1;
  localparam int BIT_TIMEOUT = 0;
  localparam int BIT_COUNT_EN = 1;
  localparam int BIT_RESET_EN = 0;

  // ----------------------------------------------------------------
  // Route codes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] ROUTE_OFF = 4'h0;
  localparam logic [3:0] ROUTE_SMI = 4'h2;
  localparam logic [3:0] ROUTE_NO8 = 4'h8;
  localparam logic [3:0] ROUTE_NO13 = 4'hD;
  localparam logic [7:0] RST_UNIT_SEL = 8'h01;
  localparam logic [23:0] RST_RELOAD = 24'h004000;
  localparam logic [7:0] RST_MASKS = 8'hFF;
  localparam logic [15:0] RST_BASE = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } lwdt_io_req_t;

  typedef enum logic [1:0] {
    CFG_LOCKED, CFG_KEY_HALF, CFG_OPEN, CFG_EXIT_HALF
  } lwdt_cfg_t;

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic pulse;
  } lwdt_sync_t;

  typedef struct packed {
    lwdt_cfg_t cfg;
    logic [7:0] index;
    logic [7:0] unit_sel;
    logic active;
    logic [15:0] base;
    logic [3:0] route;
    logic [4:0] restart_en;
    logic [15:0] win1;
    logic [15:0] win2;
    logic [7:0] masks;
    logic [23:0] count;
    logic [23:0] reload;
    logic timeout_flag;
    logic second_timeout_flag;
    logic countdown_enable;
    logic reset_on_timeout_enable;
    logic ack;
    logic [7:0] rdata;
    logic [15:0] irq;
    logic smi;
    logic sys_reset;
  } lwdt_state_t;

endpackage : lwdt_pkg

// ===== hw/lwdt_tick_sync.sv
// Two-stage synchroniser and edge detector for the slow tick pin.
// Assumes the tick is far slower than the 250 MHz clock.
module lwdt_tick_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Tick pin and its rising-edge pulse
  input wire logic i_tick,
  output logic o_pulse
);

  lwdt_pkg::lwdt_sync_t r_reg;
  lwdt_pkg::lwdt_sync_t r_next;

  // Only the second stage feeds the edge detector
  always_comb begin
    r_next = r_reg;
    r_next.meta = i_tick;
    r_next.sync = r_reg.meta;
    r_next.last = r_reg.sync;
    r_next.pulse = r_reg.sync & ~r_reg.last;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_pulse = r_reg.pulse;

endmodule : lwdt_tick_sync

// ===== hw/lwdt_win_match.sv
// Masked address compare for one restart window.
// Assumes the mask bits mark low address bits that are ignored.
module lwdt_win_match (
  // Address under test and window setup
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_base,
  input wire logic [3:0] i_mask,
  // Result
  output logic o_hit
);

  logic [15:0] care;

  // Mask of all ones gives a 16-byte window, zero a single byte
  assign care = ~{12'h000, i_mask};
  assign o_hit = ((i_addr ^ i_base) & care) == 16'h0000;

endmodule : lwdt_win_match

// ===== hw/lwdt_top.sv
// Watchdog timer unit on the host I/O bus: key-locked configuration
// ports, a base-relative register block, countdown and routing.
// Assumes a decoder that presents each host I/O cycle as one pulse.
//
// Contract
// (RULE1) Route code 0, 8, 13, 14, 15 disables; 2 picks SMI; else IRQ.
// (RULE2) With postcode enable set, writes to port 80h restart the count.
// (RULE3) Second-window write restart enable makes window writes restart.
// (RULE4) Second-window read restart enable makes window reads restart.
// (RULE5) First-window write restart enable makes window writes restart.
// (RULE6) First-window read restart enable makes window reads restart.
// (RULE7) First window base is 16 bits from two host-visible bytes.
// (RULE8) Second window base is 16 bits from two host-visible bytes.
// (RULE9) Mask byte: first window mask high nibble, second low nibble.
// (RULE10) Block base address is two readable and writable bytes.
// (RULE11) Current count appears as three bytes at offsets 0 to 2.
// (RULE12) Reload value appears as three bytes at offsets 3 to 5.
// (RULE13) Expiry sets the timeout flag, which gates the routed interrupt.
// (RULE14) Timeout flag clears on write-one, postcode or window restarts.
// (RULE15) Second timeout sets when flag already set and reset enabled.
// (RULE16) Read-only status bit 1 shows SMI is the selected route.
// (RULE17) Counter decrements only while countdown enable is one.
// (RULE18) System reset request only while reset-on-timeout enable is one.
// (RULE19) One decrement per period of the 32.768 kHz tick.
// (RULE20) Key 46h 57h unlocks, 57h 46h relocks the configuration ports.
// (RULE21) Index written at 302h, register contents reached at 303h.
// (RULE22) Any write to the current count restarts the timeout period.
// (RULE23) Every restart reloads the count from the reload value.
// (RULE24) Window hit ignores masked low address bits, 1 to 16 bytes.
module lwdt_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Host I/O cycle, one pulse per cycle
  input wire lwdt_pkg::lwdt_io_req_t i_io,
  output logic o_io_ack,
  output logic [7:0] o_io_rdata,
  // Slow tick pin
  input wire logic i_tick,
  // Timeout outputs
  output logic [15:0] o_irq,
  output logic o_smi,
  output logic o_sys_reset
);

  lwdt_pkg::lwdt_state_t r_reg;
  lwdt_pkg::lwdt_state_t r_next;

  // ----------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------
  logic tick;
  logic io_wr;
  logic io_rd;
  logic unlocked;
  logic at_index;
  logic at_data;
  logic unit_ok;
  logic cfg_blk;
  logic io_blk;
  logic blk_wr;
  logic blk_rd;
  logic [2:0] ofs;
  logic win1_hit;
  logic win2_hit;
  logic postcode_rst;
  logic win_rst;
  logic strobe;
  logic restart;
  logic expire;
  logic cfg_wr;
  logic cfg_rd;
  logic [15:0] irq_dec;
  logic [7:0] blk_q;
  logic [7:0] cfg_q;
  logic [7:0] flags_q;
  logic [4:0] en;

  lwdt_tick_sync u_tick (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_tick(i_tick),
    .o_pulse(tick)
  );

  lwdt_win_match u_win1 (
    .i_addr(i_io.addr),
    .i_base(r_reg.win1),
    .i_mask(r_reg.masks[7:4]),
    .o_hit(win1_hit)
  ); // RULE9 RULE24

  lwdt_win_match u_win2 (
    .i_addr(i_io.addr),
    .i_base(r_reg.win2),
    .i_mask(r_reg.masks[3:0]),
    .o_hit(win2_hit)
  ); // RULE9 RULE24

  assign en = r_reg.restart_en;
  assign io_wr = i_io.valid & i_io.write;
  assign io_rd = i_io.valid & ~i_io.write;
  assign unlocked = (r_reg.cfg == lwdt_pkg::CFG_OPEN) |
                    (r_reg.cfg == lwdt_pkg::CFG_EXIT_HALF);
  assign at_index = i_io.addr == lwdt_pkg::CFG_INDEX_PORT;
  assign at_data = (i_io.addr == lwdt_pkg::CFG_DATA_PORT) & unlocked;
  assign unit_ok = r_reg.unit_sel == lwdt_pkg::UNIT_WDT;
  assign cfg_blk = at_data & unit_ok &
                   (r_reg.index[7:3] == lwdt_pkg::IDX_BLOCK[7:3]);
  // Block base bits 2:0 are ignored so the block stays 8-aligned
  assign io_blk = r_reg.active & ~at_data &
                  (i_io.addr[15:3] == r_reg.base[15:3]);
  assign ofs = io_blk ? i_io.addr[2:0] : r_reg.index[2:0];
  assign blk_wr = io_wr & (io_blk | cfg_blk);
  assign blk_rd = io_rd & (io_blk | cfg_blk);
  assign cfg_wr = io_wr & at_data & ~cfg_blk;
  assign cfg_rd = io_rd & at_data & ~cfg_blk;

  // ----------------------------------------------------------------
  // Restart sources
  // ----------------------------------------------------------------
  assign postcode_rst = io_wr &
    (i_io.addr == lwdt_pkg::POSTCODE_PORT) &
    en[lwdt_pkg::BIT_POSTCODE_EN]; // RULE2
  assign win_rst =
    (io_wr & win2_hit & en[lwdt_pkg::BIT_WIN2_WR_EN]) | // RULE3
    (io_rd & win2_hit & en[lwdt_pkg::BIT_WIN2_RD_EN]) | // RULE4
    (io_wr & win1_hit & en[lwdt_pkg::BIT_WIN1_WR_EN]) | // RULE5
    (io_rd & win1_hit & en[lwdt_pkg::BIT_WIN1_RD_EN]); // RULE6
  assign strobe = blk_wr & (ofs <= lwdt_pkg::OFS_NOW2); // RULE22
  assign restart = strobe | postcode_rst | win_rst;
  // A count of one or zero expires on the next tick
  assign expire = tick & r_reg.countdown_enable &
                  (r_reg.count <= 24'h000001); // RULE19

  // ----------------------------------------------------------------
  // Interrupt line decode
  // ----------------------------------------------------------------
  function automatic logic route_is_line(input logic [3:0] code);
    route_is_line = (code != lwdt_pkg::ROUTE_OFF) &&
                    (code != lwdt_pkg::ROUTE_SMI) &&
                    (code != lwdt_pkg::ROUTE_NO8) &&
                    (code < lwdt_pkg::ROUTE_NO13);
  endfunction : route_is_line

  for (genvar g = 0; g < 16; g++) begin : g_irq
    assign irq_dec[g] = r_reg.timeout_flag &
                        (r_reg.route == 4'(g)) &
                        route_is_line(r_reg.route); // RULE1 RULE13
  end

  // ----------------------------------------------------------------
  // Read multiplexers
  // ----------------------------------------------------------------
  assign flags_q = {5'b00000, r_reg.second_timeout_flag,
                    r_reg.route == lwdt_pkg::ROUTE_SMI, // RULE16
                    r_reg.timeout_flag};

  always_comb begin
    blk_q = 8'h00;
    case (ofs)
      3'h0: blk_q = r_reg.count[7:0]; // RULE11
      3'h1: blk_q = r_reg.count[15:8];
      3'h2: blk_q = r_reg.count[23:16];
      3'h3: blk_q = r_reg.reload[7:0]; // RULE12
      3'h4: blk_q = r_reg.reload[15:8];
      3'h5: blk_q = r_reg.reload[23:16];
      3'h6: blk_q = flags_q;
      default: blk_q = {6'b000000, r_reg.countdown_enable,
                        r_reg.reset_on_timeout_enable};
    endcase
  end

  always_comb begin
    cfg_q = 8'h00;
    if (r_reg.index == lwdt_pkg::IDX_UNIT_SEL) begin
      cfg_q = r_reg.unit_sel;
    end else if (!unit_ok) begin
      cfg_q = 8'h00;
    end else if (r_reg.index == lwdt_pkg::IDX_ACTIVATE) begin
      cfg_q = {7'b0000000, r_reg.active};
    end else if (r_reg.index == lwdt_pkg::IDX_BASE_HIGH) begin
      cfg_q = r_reg.base[15:8]; // RULE10
    end else if (r_reg.index == lwdt_pkg::IDX_BASE_LOW) begin
      cfg_q = r_reg.base[7:0]; // RULE10
    end else if (r_reg.index == lwdt_pkg::IDX_IRQ_ROUTE) begin
      cfg_q = {4'h0, r_reg.route};
    end else if (r_reg.index == lwdt_pkg::IDX_RESTART_EN) begin
      cfg_q = {3'b000, en};
    end else if (r_reg.index == lwdt_pkg::IDX_WIN1_LOW) begin
      cfg_q = r_reg.win1[7:0]; // RULE7
    end else if (r_reg.index == lwdt_pkg::IDX_WIN1_HIGH) begin
      cfg_q = r_reg.win1[15:8]; // RULE7
    end else if (r_reg.index == lwdt_pkg::IDX_WIN2_LOW) begin
      cfg_q = r_reg.win2[7:0]; // RULE8
    end else if (r_reg.index == lwdt_pkg::IDX_WIN2_HIGH) begin
      cfg_q = r_reg.win2[15:8]; // RULE8
    end else if (r_reg.index == lwdt_pkg::IDX_WIN_MASKS) begin
      cfg_q = r_reg.masks; // RULE9
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.ack = 1'b0;
    r_next.rdata = 8'h00;

    // Key sequence on the index port
    if (io_wr && at_index) begin
      case (r_reg.cfg)
        lwdt_pkg::CFG_LOCKED: begin
          if (i_io.wdata == lwdt_pkg::KEY_FIRST) begin
            r_next.cfg = lwdt_pkg::CFG_KEY_HALF; // RULE20
          end
        end
        lwdt_pkg::CFG_KEY_HALF: begin
          if (i_io.wdata == lwdt_pkg::KEY_SECOND) begin
            r_next.cfg = lwdt_pkg::CFG_OPEN; // RULE20
          end else if (i_io.wdata != lwdt_pkg::KEY_FIRST) begin
            r_next.cfg = lwdt_pkg::CFG_LOCKED;
          end
        end
        lwdt_pkg::CFG_OPEN: begin
          r_next.index = i_io.wdata; // RULE21
          if (i_io.wdata == lwdt_pkg::KEY_SECOND) begin
            r_next.cfg = lwdt_pkg::CFG_EXIT_HALF;
          end
        end
        default: begin
          r_next.index = i_io.wdata;
          if (i_io.wdata == lwdt_pkg::KEY_FIRST) begin
            r_next.cfg = lwdt_pkg::CFG_LOCKED; // RULE20
          end else if (i_io.wdata != lwdt_pkg::KEY_SECOND) begin
            r_next.cfg = lwdt_pkg::CFG_OPEN;
          end
        end
      endcase
    end

    // Configuration register writes through the data port
    if (cfg_wr) begin
      if (r_reg.index == lwdt_pkg::IDX_UNIT_SEL) begin
        r_next.unit_sel = i_io.wdata;
      end else if (!unit_ok) begin
        r_next.unit_sel = r_reg.unit_sel;
      end else if (r_reg.index == lwdt_pkg::IDX_ACTIVATE) begin
        r_next.active = i_io.wdata[0];
      end else if (r_reg.index == lwdt_pkg::IDX_BASE_HIGH) begin
        r_next.base[15:8] = i_io.wdata; // RULE10
      end else if (r_reg.index == lwdt_pkg::IDX_BASE_LOW) begin
        r_next.base[7:0] = i_io.wdata; // RULE10
      end else if (r_reg.index == lwdt_pkg::IDX_IRQ_ROUTE) begin
        r_next.route = i_io.wdata[3:0];
      end else if (r_reg.index == lwdt_pkg::IDX_RESTART_EN) begin
        r_next.restart_en = i_io.wdata[4:0];
      end else if (r_reg.index == lwdt_pkg::IDX_WIN1_LOW) begin
        r_next.win1[7:0] = i_io.wdata; // RULE7
      end else if (r_reg.index == lwdt_pkg::IDX_WIN1_HIGH) begin
        r_next.win1[15:8] = i_io.wdata; // RULE7
      end else if (r_reg.index == lwdt_pkg::IDX_WIN2_LOW) begin
        r_next.win2[7:0] = i_io.wdata; // RULE8
      end else if (r_reg.index == lwdt_pkg::IDX_WIN2_HIGH) begin
        r_next.win2[15:8] = i_io.wdata; // RULE8
      end else if (r_reg.index == lwdt_pkg::IDX_WIN_MASKS) begin
        r_next.masks = i_io.wdata; // RULE9
      end
    end

    // Block register writes; count bytes only strobe
    if (blk_wr) begin
      if (ofs == lwdt_pkg::OFS_RELOAD0) begin
        r_next.reload[7:0] = i_io.wdata; // RULE12
      end else if (ofs == lwdt_pkg::OFS_RELOAD1) begin
        r_next.reload[15:8] = i_io.wdata;
      end else if (ofs == lwdt_pkg::OFS_RELOAD2) begin
        r_next.reload[23:16] = i_io.wdata;
      end else if (ofs == lwdt_pkg::OFS_FLAGS) begin
        if (i_io.wdata[lwdt_pkg::BIT_TIMEOUT]) begin
          r_next.timeout_flag = 1'b0; // RULE14
        end
        if (i_io.wdata[lwdt_pkg::BIT_SECOND_TO]) begin
          r_next.second_timeout_flag = 1'b0; // RULE15
        end
      end else if (ofs == lwdt_pkg::OFS_CONTROL) begin
        r_next.countdown_enable = i_io.wdata[lwdt_pkg::BIT_COUNT_EN];
        r_next.reset_on_timeout_enable =
          i_io.wdata[lwdt_pkg::BIT_RESET_EN];
      end
    end

    if (postcode_rst || win_rst) begin
      r_next.timeout_flag = 1'b0; // RULE14
    end

    // Counter: restart outranks the tick; reload uses the old value
    if (restart) begin
      r_next.count = r_reg.reload; // RULE23
    end else if (expire) begin
      r_next.count = r_reg.reload;
    end else if (tick && r_reg.countdown_enable) begin
      r_next.count = r_reg.count - 24'h000001; // RULE17 RULE19
    end

    // Flag set wins over a clear in the same cycle
    if (expire) begin
      r_next.timeout_flag = 1'b1; // RULE13
      if (r_reg.timeout_flag && r_reg.reset_on_timeout_enable) begin
        r_next.second_timeout_flag = 1'b1; // RULE15
      end
    end

    // Read data and acknowledge
    if (blk_rd) begin
      r_next.rdata = blk_q;
    end else if (cfg_rd) begin
      r_next.rdata = cfg_q;
    end else if (io_rd && at_index && unlocked) begin
      r_next.rdata = r_reg.index;
    end
    r_next.ack = blk_wr | blk_rd | cfg_wr | cfg_rd | (io_wr & at_index) |
                 (io_rd & at_index & unlocked);

    // Outputs follow the flags one cycle later
    r_next.irq = irq_dec;
    r_next.smi = r_reg.timeout_flag &
                 (r_reg.route == lwdt_pkg::ROUTE_SMI); // RULE1
    r_next.sys_reset = r_reg.second_timeout_flag &
                       r_reg.reset_on_timeout_enable; // RULE18
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg <= '0;
      r_reg.cfg <= lwdt_pkg::CFG_LOCKED;
      r_reg.unit_sel <= lwdt_pkg::RST_UNIT_SEL;
      r_reg.base <= lwdt_pkg::RST_BASE;
      r_reg.masks <= lwdt_pkg::RST_MASKS;
      r_reg.reload <= lwdt_pkg::RST_RELOAD;
      r_reg.count <= lwdt_pkg::RST_RELOAD;
      r_reg.countdown_enable <= 1'b1;
      r_reg.reset_on_timeout_enable <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_io_ack = r_reg.ack;
  assign o_io_rdata = r_reg.rdata;
  assign o_irq = r_reg.irq;
  assign o_smi = r_reg.smi;
  assign o_sys_reset = r_reg.sys_reset;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_postcode_wr;
    io_wr && i_io.addr == lwdt_pkg::POSTCODE_PORT;
  endsequence

  sequence s_win1_wr;
    io_wr && win1_hit && en[lwdt_pkg::BIT_WIN1_WR_EN];
  endsequence

  sequence s_reloaded;
    r_reg.count == $past(r_reg.reload);
  endsequence

  postcode_restart_a: assert property ( // RULE2
    s_postcode_wr ##0 en[lwdt_pkg::BIT_POSTCODE_EN] |=> s_reloaded
  ) else $error("postcode write did not reload the count");

  window_restart_a: assert property ( // RULE5
    s_win1_wr |=> s_reloaded ##0 !r_reg.timeout_flag || $past(expire)
  ) else $error("window write did not restart");

  timeout_set_a: assert property ( // RULE13
    expire |=> r_reg.timeout_flag ##1 (o_smi ==
      (r_reg.route == lwdt_pkg::ROUTE_SMI) || $past(restart))
  ) else $error("expiry did not raise the timeout flag");

  second_timeout_a: assert property ( // RULE15
    expire && r_reg.timeout_flag && r_reg.reset_on_timeout_enable
      |=> r_reg.second_timeout_flag ##1 o_sys_reset ||
          !$past(r_reg.reset_on_timeout_enable)
  ) else $error("second timeout not flagged");

  irq_gate_a: assert property ( // RULE1
    o_irq != 16'h0000 |-> $past(r_reg.timeout_flag) &&
      o_irq == (16'h0001 << $past(r_reg.route)) &&
      $past(r_reg.route) != lwdt_pkg::ROUTE_OFF &&
      $past(r_reg.route) != lwdt_pkg::ROUTE_NO8 &&
      $past(r_reg.route) != lwdt_pkg::ROUTE_SMI &&
      $past(r_reg.route) < lwdt_pkg::ROUTE_NO13
  ) else $error("interrupt line raised without a valid route");

  count_hold_a: assert property ( // RULE17
    !r_reg.countdown_enable && !restart |=> $stable(r_reg.count)
  ) else $error("count moved while countdown disabled");

  reset_gate_a: assert property ( // RULE18
    o_sys_reset |-> $past(r_reg.reset_on_timeout_enable)
  ) else $error("reset request without reset enable");

  locked_data_a: assert property ( // RULE20
    r_reg.cfg == lwdt_pkg::CFG_LOCKED && i_io.valid &&
      i_io.addr == lwdt_pkg::CFG_DATA_PORT && !io_blk |=> !o_io_ack
  ) else $error("data port answered while locked");

  strobe_reload_a: assert property ( // RULE22
    blk_wr && ofs == lwdt_pkg::OFS_NOW0 |=> s_reloaded
  ) else $error("count write did not restart the period");

endmodule : lwdt_top

// ===== verif/lwdt_host.sv
// Host bus controller model: one I/O cycle per call of io.
// Assumes the device answers one cycle after the taken edge.
module lwdt_host (
  // Clock
  input wire logic i_clk,
  // Cycle to device
  output lwdt_pkg::lwdt_io_req_t o_io
);
  timeunit 1ns;
  timeprecision 1ps;
  logic was_rd = 1'b0;
  initial o_io = '0;
  // Released fields turn to inverted junk, never the old value
  task automatic io(input logic w, input logic [15:0] a,
                    input logic [7:0] d);
    @(negedge i_clk);
    was_rd = !w;
    o_io = {1'b1, w, a, d};
    @(negedge i_clk);
    o_io = {1'b0, !w, ~a, ~d};
  endtask : io
endmodule : lwdt_host

// ===== verif/lwdt_watchdog_timer_test.sv
// Self-checking bench for the watchdog unit on the host I/O bus.
// Assumes lwdt_pkg, the design and lwdt_host are compiled first.
module lwdt_watchdog_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] B = 16'h0310;
  localparam logic [7:0] RI [9] = '{8'h60, 8'h61, 8'h70, 8'hF1,
    8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6};
  localparam logic [7:0] RM [9] = '{8'hFF, 8'hF8, 8'h0F, 8'h1F,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [15:0] HA [5] = '{16'h0403, 16'h0401, 16'h0500,
    16'h0500, 16'h0080};
  localparam logic HW [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_tick = 1'b0;
  lwdt_pkg::lwdt_io_req_t io;
  logic ack;
  logic [7:0] rdat;
  logic [15:0] irq;
  logic smi;
  logic sysrst;
  int errors = 0;
  int comparisons = 0;
  logic [7:0] q[$];
  always #2 i_clk = ~i_clk;
  lwdt_host h (.i_clk(i_clk), .o_io(io));
  lwdt_top dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_io(io),
    .o_io_ack(ack), .o_io_rdata(rdat), .i_tick(i_tick),
    .o_irq(irq), .o_smi(smi), .o_sys_reset(sysrst));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic cmp8(string n, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (e !== g) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : cmp8
  task automatic cmp16(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (e !== g) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : cmp16
  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic wr(logic [15:0] a, logic [7:0] d);
    h.io(1'b1, a, d);
  endtask : wr
  // Expected data is noted before the cycle; the monitor pops it
  task automatic rd(logic [15:0] a, logic [7:0] e);
    q.push_back(e);
    h.io(1'b0, a, 8'h00);
  endtask : rd
  task automatic cw(logic [7:0] i, logic [7:0] d);
    wr(16'h0302, i);
    wr(16'h0303, d);
  endtask : cw
  task automatic cr(logic [7:0] i, logic [7:0] e);
    wr(16'h0302, i);
    rd(16'h0303, e);
  endtask : cr
  // Eleven clocks a period leaves room for the two-flop synchroniser
  task automatic tick();
    @(negedge i_clk) i_tick = 1'b1;
    repeat (5) @(negedge i_clk);
    i_tick = 1'b0;
    repeat (5) @(negedge i_clk);
  endtask : tick
  task automatic expire();
    wr(B, 8'h00);
    repeat (5) tick();
  endtask : expire
  // Ack stands from one rising edge to the next; look in between
  always @(negedge i_clk) begin
    if (ack === 1'b1 && h.was_rd && q.size() > 0) begin
      cmp8("rdata", q.pop_front(), rdat);
    end
  end
  initial begin
    #200us;
    errors++;
    final_report();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    int c;
    int s;
    c = $urandom(7291);
    repeat (10) @(negedge i_clk);
    i_nrst = 1'b1;
    h.io(1'b0, 16'h0303, 8'h00);
    cmp16("locked ack", 16'h0000, {15'h0, ack});
    wr(16'h0302, 8'h46);
    wr(16'h0302, 8'h57);
    cw(8'h07, 8'h01);
    cr(8'hF6, 8'hFF);
    cr(8'h3C, 8'h40);
    cr(8'h3E, 8'h00);
    cr(8'h3F, 8'h03);
    $display("test reset values done");
    for (s = 0; s < 9; s++) begin
      c = $urandom & RM[s];
      cw(RI[s], 8'(c));
      cr(RI[s], 8'(c));
    end
    $display("test register access done");
    cw(8'hF1, 8'h00);
    cw(8'h60, 8'h03);
    cw(8'h61, 8'h10);
    cw(8'h30, 8'h01);
    cw(8'hF2, 8'h00);
    cw(8'hF3, 8'h04);
    cw(8'hF4, 8'h00);
    cw(8'hF5, 8'h05);
    cw(8'hF6, 8'h30);
    wr(B + 3, 8'h05);
    wr(B + 4, 8'h00);
    rd(B + 3, 8'h05);
    for (c = 0; c < 16; c++) begin
      cw(8'h70, 8'(c));
      expire();
      cmp16("irq", (c inside {0, 2, 8, 13, 14, 15}) ? 16'h0000 :
        16'h0001 << c, irq);
      cmp16("smi", 16'(c == 2), {15'h0, smi});
      rd(B + 6, {6'h00, c == 2, 1'b1});
      wr(B + 6, 8'h07);
      @(negedge i_clk);
      cmp16("irq off", 16'h0000, irq);
    end
    cw(8'h70, 8'h01);
    expire();
    repeat (5) tick();
    cmp16("sys reset", 16'h0001, {15'h0, sysrst});
    rd(B + 6, 8'h05);
    wr(B + 7, 8'h02);
    wr(B + 6, 8'h07);
    expire();
    repeat (5) tick();
    cmp16("no sys reset", 16'h0000, {15'h0, sysrst});
    wr(B + 7, 8'h00);
    wr(B + 6, 8'h07);
    expire();
    rd(B + 6, 8'h00);
    wr(B + 7, 8'h03);
    $display("test timeouts done");
    // Hit, wrong direction, outside the masked window
    for (s = 0; s < 5; s++) begin
      cw(8'hF1, 8'h01 << s);
      for (c = 0; c < 3; c++) begin
        wr(B, 8'h00);
        repeat (2) tick();
        h.io(HW[s] ^ (c == 1), HA[s] + (c == 2 ? 16'h10 : 16'h0), 8'h5A);
        rd(B, c == 0 ? 8'h05 : 8'h03);
      end
    end
    $display("test restart sources done");
    wr(16'h0302, 8'h57);
    wr(16'h0302, 8'h46);
    h.io(1'b0, 16'h0303, 8'h00);
    cmp16("relocked ack", 16'h0000, {15'h0, ack});
    $display("test relock done");
    cmp16("unanswered", 16'h0000, 16'(q.size()));
    final_report();
  end
endmodule : lwdt_watchdog_timer_test
